// file: design/tlb_mmu_regs.vh
`ifndef TLB_MMU_REGS_VH
`define TLB_MMU_REGS_VH
`define REG_REGION0_BASE 6'h08
`define REG_REGION0_LEN 6'h09
`define REG_REGION1_BASE 6'h0a
`define REG_REGION1_LEN 6'h0b
`define REG_SYSTEM_BASE 6'h0c
`define REG_SYSTEM_LEN 6'h0d
`define REG_DIAG_TAG 6'h2f
`define REG_XLATE_EN 6'h38
`define REG_INV_ALL 6'h39
`define REG_INV_ONE 6'h3a
`define REG_DIAG_ENTRY 6'h3b
`define REG_PROBE 6'h3f
`define TLB_ENTRIES 64
`define TAG_W 24
`define ENTRY_W 27
`define VPN_HI 31
`define VPN_LO 9
`define PFN_W 21
`define PTE_PRESENT_BIT 31
`define PTE_MODIFIED_BIT 26
`define PTE_PROTECTION_CODE_HI 30
`define PTE_PROTECTION_CODE_LO 27
`define PTE_PFN_HI 20
`define PSL_OVERFLOW_BIT 1
`define XLATE_EN_RESET 1'b0
`endif

// file: design/tlb_memory_management.v
`timescale 1ns/1ps
`default_nettype none
`include "tlb_mmu_regs.vh"

module tlb_memory_management #(
    parameter ENTRIES = `TLB_ENTRIES,
    parameter IDX_W = 6
) (
    input wire clk_sys_i,
    input wire rstn_i,
    // processor register port
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [5:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    output reg [31:0] reg_rdata_o,
    output reg reg_ack_o,
    output reg reserved_operand_fault_o,
    output reg probe_valid_o,
    output reg probe_overflow_o,
    input wire load_context_i,
    // translation request from pipeline
    input wire xlate_req_i,
    input wire [31:0] xlate_va_i,
    output reg xlate_ack_o,
    output reg [31:0] xlate_pa_o,
    output reg [3:0] xlate_protection_code_o,
    output reg xlate_modified_o,
    output reg xlate_fault_o,
    // memory fetch path
    output reg mem_req_o,
    output reg [31:0] mem_addr_o,
    input wire mem_ack_i,
    input wire [31:0] mem_rdata_i
);

    localparam ST_IDLE = 3'd0;
    localparam ST_SYS = 3'd1;
    localparam ST_PROC_SYS = 3'd2;
    localparam ST_PROC = 3'd3;
    localparam ST_DONE = 3'd4;

    reg [`TAG_W-2:0] tag_vpn [0:ENTRIES-1];
    reg [ENTRIES-1:0] valid_reg;
    reg [`ENTRY_W-1:0] entry_part [0:ENTRIES-1];
    reg [IDX_W-1:0] ptr_reg;
    reg xlate_en_reg;
    reg [31:0] r0_base_reg, r0_len_reg, r1_base_reg, r1_len_reg, s_base_reg, s_len_reg;
    reg [2:0] state_reg;
    reg [31:0] va_reg;
    reg [31:0] pte_reg;
    integer i;

    // packed entry: present, protection_code[3:0], modified, pfn[20:0]
    function [`ENTRY_W-1:0] pack_pte;
        input [31:0] page_table_entry;
        pack_pte = {page_table_entry[`PTE_PRESENT_BIT], page_table_entry[`PTE_PROTECTION_CODE_HI:`PTE_PROTECTION_CODE_LO],
                    page_table_entry[`PTE_MODIFIED_BIT], page_table_entry[`PTE_PFN_HI:0]};
    endfunction

    function tag_hit;
        input valid;
        input [`TAG_W-2:0] tag;
        input [31:0] va;
        tag_hit = valid && (tag == va[`VPN_HI:`VPN_LO]);
    endfunction

    // flags and tags are read here, not inside the function, so a flush
    // re-evaluates the compare even while the address stays put
    reg [ENTRIES-1:0] hit_vec;
    reg [ENTRIES-1:0] probe_vec;
    reg [IDX_W-1:0] hit_idx;
    integer n;
    always @* begin
        hit_vec = {ENTRIES{1'b0}};
        probe_vec = {ENTRIES{1'b0}};
        hit_idx = {IDX_W{1'b0}};
        for (n = 0; n < ENTRIES; n = n + 1) begin
            hit_vec[n] = tag_hit(valid_reg[n], tag_vpn[n], xlate_va_i);
            probe_vec[n] = tag_hit(valid_reg[n], tag_vpn[n], reg_wdata_i);
            if (hit_vec[n]) begin
                hit_idx = n[IDX_W-1:0];
            end
        end
    end
    wire hit_any = |hit_vec;
    wire [`ENTRY_W-1:0] hit_entry = entry_part[hit_idx];

    wire flush_wr = reg_wr_i && ((reg_addr_i >= `REG_REGION0_BASE && reg_addr_i <= `REG_SYSTEM_LEN)
        || reg_addr_i == `REG_XLATE_EN || reg_addr_i == `REG_INV_ALL
        || reg_addr_i == `REG_INV_ONE);
    wire ptr_reset = reg_wr_i && (reg_addr_i == `REG_XLATE_EN ||
        reg_addr_i == `REG_INV_ALL);
    wire busy = (state_reg != ST_IDLE);
    wire [IDX_W-1:0] ptr_inc = ptr_reg + {{(IDX_W-1){1'b0}}, 1'b1};
    wire [31:0] sys_vpn_off = {9'h000, va_reg[29:9], 2'b00};
    wire [31:0] proc_pte_va = (va_reg[30] ? r1_base_reg : r0_base_reg) + sys_vpn_off;

    // table entry address for a system-space virtual address
    function [31:0] sys_pte_pa;
        input [31:0] sva;
        sys_pte_pa = s_base_reg + {9'h000, sva[29:9], 2'b00};
    endfunction

    // array words have no reset; their valid flags guard them after reset
    wire diag_tag_wr = reg_wr_i && (reg_addr_i == `REG_DIAG_TAG);
    wire diag_entry_wr = reg_wr_i && (reg_addr_i == `REG_DIAG_ENTRY);

    // a fill completing in the same cycle wins the slot over a diagnostic write
    always @(posedge clk_sys_i) begin
        if (state_reg == ST_DONE) begin
            tag_vpn[ptr_reg] <= va_reg[`VPN_HI:`VPN_LO];
            entry_part[ptr_reg] <= pack_pte(pte_reg);
        end else begin
            if (diag_tag_wr) begin
                tag_vpn[ptr_reg] <= reg_wdata_i[`VPN_HI:`VPN_LO];
            end
            if (diag_entry_wr) begin
                entry_part[ptr_reg] <= pack_pte(reg_wdata_i);
            end
        end
    end

    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            valid_reg <= {ENTRIES{1'b0}};
            ptr_reg <= {IDX_W{1'b0}};
            xlate_en_reg <= `XLATE_EN_RESET;
            r0_base_reg <= 32'h0000_0000;
            r0_len_reg <= 32'h0000_0000;
            r1_base_reg <= 32'h0000_0000;
            r1_len_reg <= 32'h0000_0000;
            s_base_reg <= 32'h0000_0000;
            s_len_reg <= 32'h0000_0000;
            reg_rdata_o <= 32'h0000_0000;
            reg_ack_o <= 1'b0;
            reserved_operand_fault_o <= 1'b0;
            probe_valid_o <= 1'b0;
            probe_overflow_o <= 1'b0;
            xlate_ack_o <= 1'b0;
            xlate_pa_o <= 32'h0000_0000;
            xlate_protection_code_o <= 4'h0;
            xlate_modified_o <= 1'b0;
            xlate_fault_o <= 1'b0;
            mem_req_o <= 1'b0;
            mem_addr_o <= 32'h0000_0000;
            state_reg <= ST_IDLE;
            va_reg <= 32'h0000_0000;
            pte_reg <= 32'h0000_0000;
        end else begin
            reg_ack_o <= reg_wr_i | reg_rd_i;
            reserved_operand_fault_o <= 1'b0;
            probe_valid_o <= 1'b0;
            xlate_ack_o <= 1'b0;
            xlate_fault_o <= 1'b0;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `REG_REGION0_BASE: reg_rdata_o <= r0_base_reg;
                    `REG_REGION0_LEN: reg_rdata_o <= r0_len_reg;
                    `REG_REGION1_BASE: reg_rdata_o <= r1_base_reg;
                    `REG_REGION1_LEN: reg_rdata_o <= r1_len_reg;
                    `REG_SYSTEM_BASE: reg_rdata_o <= s_base_reg;
                    `REG_SYSTEM_LEN: reg_rdata_o <= s_len_reg;
                    `REG_XLATE_EN: reg_rdata_o <= {31'h0000_0000, xlate_en_reg};
                    `REG_DIAG_TAG, `REG_INV_ALL, `REG_INV_ONE, `REG_DIAG_ENTRY,
                    `REG_PROBE: begin
                        reg_rdata_o <= 32'h0000_0000;
                        reserved_operand_fault_o <= 1'b1;
                    end
                    default: reg_rdata_o <= 32'h0000_0000;
                endcase
            end
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `REG_REGION0_BASE: r0_base_reg <= reg_wdata_i;
                    `REG_REGION0_LEN: r0_len_reg <= reg_wdata_i;
                    `REG_REGION1_BASE: r1_base_reg <= reg_wdata_i;
                    `REG_REGION1_LEN: r1_len_reg <= reg_wdata_i;
                    `REG_SYSTEM_BASE: s_base_reg <= reg_wdata_i;
                    `REG_SYSTEM_LEN: s_len_reg <= reg_wdata_i;
                    `REG_XLATE_EN: xlate_en_reg <= reg_wdata_i[0];
                    `REG_PROBE: begin
                        probe_valid_o <= 1'b1;
                        probe_overflow_o <= |probe_vec;
                    end
                    `REG_DIAG_ENTRY: begin
                        ptr_reg <= ptr_inc;
                    end
                    default: ;
                endcase
            end
            // valid flags: flush covers tb-one too, a superset of per-address invalidation
            if (flush_wr) begin
                valid_reg <= {ENTRIES{1'b0}};
            end else if (diag_tag_wr) begin
                valid_reg[ptr_reg] <= 1'b0;
            end else if (diag_entry_wr) begin
                valid_reg[ptr_reg] <= 1'b1;
            end else if (load_context_i) begin
                for (i = 0; i < ENTRIES; i = i + 1) begin
                    if (!tag_vpn[i][`VPN_HI-`VPN_LO]) begin
                        valid_reg[i] <= 1'b0;
                    end
                end
            end else if (state_reg == ST_DONE) begin
                valid_reg[ptr_reg] <= 1'b1;
            end
            // translation pipeline; stalls behind register writes
            case (state_reg)
                ST_IDLE: begin
                    // ack still high: the held request belongs to the answered translation
                    if (xlate_req_i && !xlate_ack_o && !reg_wr_i && !load_context_i) begin
                        if (!xlate_en_reg) begin
                            xlate_ack_o <= 1'b1;
                            xlate_pa_o <= xlate_va_i;
                            xlate_protection_code_o <= 4'h0;
                            xlate_modified_o <= 1'b0;
                        end else if (hit_any) begin
                            xlate_ack_o <= 1'b1;
                            xlate_pa_o <= {2'b00, hit_entry[`PFN_W-1:0], xlate_va_i[8:0]};
                            xlate_protection_code_o <= hit_entry[25:22];
                            xlate_modified_o <= hit_entry[21];
                            xlate_fault_o <= ~hit_entry[26];
                            if (hit_idx == ptr_reg) begin
                                ptr_reg <= ptr_inc;
                            end
                        end else begin
                            va_reg <= xlate_va_i;
                            mem_req_o <= 1'b1;
                            if (xlate_va_i[31]) begin
                                mem_addr_o <= sys_pte_pa(xlate_va_i);
                                state_reg <= ST_SYS;
                            end else begin
                                mem_addr_o <= sys_pte_pa((xlate_va_i[30] ? r1_base_reg :
                                    r0_base_reg) + {9'h000, xlate_va_i[29:9], 2'b00});
                                state_reg <= ST_PROC_SYS;
                            end
                        end
                    end
                end
                ST_PROC_SYS: begin
                    if (mem_ack_i) begin
                        // process table itself lives in system space: second level
                        mem_addr_o <= {2'b00, mem_rdata_i[`PTE_PFN_HI:0], proc_pte_va[8:0]};
                        state_reg <= ST_PROC;
                    end
                end
                ST_SYS, ST_PROC: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        pte_reg <= mem_rdata_i;
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // tag and entry words are written by the array process
                    ptr_reg <= ptr_inc;
                    xlate_ack_o <= 1'b1;
                    xlate_pa_o <= {2'b00, pte_reg[`PTE_PFN_HI:0], va_reg[8:0]};
                    xlate_protection_code_o <= pte_reg[`PTE_PROTECTION_CODE_HI:`PTE_PROTECTION_CODE_LO];
                    xlate_modified_o <= pte_reg[`PTE_MODIFIED_BIT];
                    xlate_fault_o <= ~pte_reg[`PTE_PRESENT_BIT];
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
            if (busy && flush_wr && state_reg == ST_DONE) begin
                state_reg <= ST_IDLE;
            end
            // last, so an enable or invalidate-all write beats the pointer step of a fill ending now
            if (ptr_reset) begin
                ptr_reg <= {IDX_W{1'b0}};
            end
        end
    end

endmodule // tlb_memory_management
`default_nettype wire

// file: tb/tlb_mmu_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tlb_mmu_asserts (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic reg_ack_o,
    input wire logic reserved_operand_fault_o,
    input wire logic probe_valid_o,
    input wire logic probe_overflow_o,
    input wire logic xlate_req_i,
    input wire logic xlate_ack_o,
    input wire logic mem_req_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic mem_ack_i
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    wire wo = reg_addr_i == 6'h2f || reg_addr_i == 6'h39 || reg_addr_i == 6'h3a
        || reg_addr_i == 6'h3b || reg_addr_i == 6'h3f;
    a_reg_ack: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
        else $error("register access not answered");
    a_ack_cause: assert property (reg_ack_o |-> $past(reg_wr_i || reg_rd_i))
        else $error("answer without access");
    a_wo_fault: assert property (reg_rd_i && wo |=> reserved_operand_fault_o)
        else $error("write-only read without fault");
    a_rw_nofault: assert property (reg_rd_i && !wo |=> !reserved_operand_fault_o)
        else $error("fault on readable register");
    a_probe_pulse: assert property (reg_wr_i && reg_addr_i == 6'h3f |=> probe_valid_o)
        else $error("probe result missing");
    a_flush_probe: assert property ((reg_wr_i && reg_addr_i == 6'h39) ##2
        (reg_wr_i && reg_addr_i == 6'h3f) |=> !probe_overflow_o)
        else $error("probe hit after invalidate all");
    a_fetch_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("fetch request dropped or moved");
    a_fill_ack: assert property ($fell(mem_req_o) |-> ##[0:2] xlate_ack_o)
        else $error("no translation after fetch");
    a_fetch_cause: assert property ($rose(mem_req_o) |-> $past(xlate_req_i))
        else $error("fetch without translation");
    a_hit_nomem: assert property (xlate_ack_o |-> !mem_req_o)
        else $error("answer while fetching");
    a_ack_single: assert property (xlate_ack_o |=> !xlate_ack_o)
        else $error("held request answered twice");
endmodule // tlb_mmu_asserts
bind tlb_memory_management tlb_mmu_asserts i_chk (.clk_sys_i, .rstn_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_ack_o, .reserved_operand_fault_o, .probe_valid_o, .probe_overflow_o,
    .xlate_req_i, .xlate_ack_o, .mem_req_o, .mem_addr_o, .mem_ack_i);
`default_nettype wire

// file: tb/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic slow_i,
    input wire logic mem_req_i,
    input wire logic [31:0] mem_addr_i,
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o
);
    logic [3:0] cnt_reg;
    always @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 4'h0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 32'h0000_0000;
        end else begin
            mem_ack_o <= 1'b0;
            // bus not held once answered
            mem_rdata_o <= ~mem_rdata_o;
            if (!mem_req_i || mem_ack_o) begin
                cnt_reg <= 4'h0;
            end else if (cnt_reg == (slow_i ? 4'h6 : 4'h1)) begin
                cnt_reg <= 4'h0;
                mem_ack_o <= 1'b1;
                // absent if address bit 4, modified from bit 3, protection 3, frame from address
                mem_rdata_o <= {~mem_addr_i[4], 4'h3, mem_addr_i[3], 5'h00, mem_addr_i[22:2]};
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end
endmodule // mem_model
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, load_context_i = 0;
    logic xlate_req_i = 0, slow = 0, flt, xf, reg_ack_o, reserved_operand_fault_o;
    logic [5:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, xlate_va_i = 0, rd, pa, last_addr, reg_rdata_o, xlate_pa_o;
    logic [31:0] mem_addr_o, mem_rdata_i;
    logic [3:0] xlate_protection_code_o;
    logic probe_valid_o, probe_overflow_o, xlate_ack_o, xlate_modified_o, xlate_fault_o;
    logic mem_req_o, mem_ack_i;
    int n_fail = 0, n_checks = 0, cyc = 0, n_mem = 0, n0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    tlb_memory_management i_dut (.clk_sys_i, .rstn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .reserved_operand_fault_o, .probe_valid_o,
        .probe_overflow_o, .load_context_i, .xlate_req_i, .xlate_va_i, .xlate_ack_o,
        .xlate_pa_o, .xlate_protection_code_o, .xlate_modified_o, .xlate_fault_o, .mem_req_o,
        .mem_addr_o, .mem_ack_i, .mem_rdata_i);
    mem_model i_mem (.clk_sys_i, .rstn_i, .slow_i(slow), .mem_req_i(mem_req_o),
        .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
    always @(posedge clk_sys_i) begin
        if (mem_ack_i) begin
            n_mem++;
            last_addr <= mem_addr_o;
        end
    end
    task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task stop_test;
        if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test;
        end
    end
    task wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_wr_i <= 1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 0;
    endtask
    task rdr(input logic [5:0] a);
        @(posedge clk_sys_i);
        reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 0;
        #1 rd = reg_rdata_o;
        flt = reserved_operand_fault_o;
    endtask
    task probe(input logic [31:0] va, input logic exp);
        wr(6'h3f, va);
        #1 check("probe", probe_overflow_o, exp);
    endtask
    task xlate(input logic [31:0] va);
        @(posedge clk_sys_i);
        xlate_req_i <= 1;
        xlate_va_i <= va;
        for (int k = 0; k < 200; k++) begin
            @(posedge clk_sys_i);
            #1 if (xlate_ack_o === 1'b1) break;
        end
        check("xlate_ack", xlate_ack_o, 1);
        pa = xlate_pa_o;
        xf = xlate_fault_o;
        // ack is still high at this edge, so the held request is not taken again
        @(posedge clk_sys_i);
        xlate_req_i <= 0;
        repeat (3) @(posedge clk_sys_i);
    endtask
    task t_reset_enable;
        rdr(6'h38);
        check("enable_reset", rd, 0);
        probe(32'h8000_0400, 0);
        wr(6'h38, 1);
        wr(6'h0c, 32'h0000_1000);
        rdr(6'h38);
        check("enable", rd, 1);
    endtask
    task t_miss_hit;
        slow = 1;
        n0 = n_mem;
        xlate(32'h8000_0400);
        check("fetches", n_mem - n0, 1);
        check("fetch_addr", last_addr, 32'h0000_1008);
        check("pa", pa, {2'b00, last_addr[22:2], 9'h000});
        check("protection_code", xlate_protection_code_o, 3);
        check("modified", xlate_modified_o, 1);
        check("present", xf, 0);
        xlate(32'h8000_05ff);
        check("hit", n_mem - n0, 1);
        check("pa_hit", pa, {2'b00, last_addr[22:2], 9'h1ff});
        probe(32'h8000_0400, 1);
        wr(6'h3a, 32'h8000_0400);
        probe(32'h8000_0400, 0);
        slow = 0;
    endtask
    task t_flushes;
        logic [5:0] a;
        logic [5:0] adr [9] = '{6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h38, 6'h39, 6'h3a};
        for (int i = 0; i < 9; i++) begin
            a = adr[i];
            xlate(32'h8000_0200);
            probe(32'h8000_0200, 1);
            wr(a, a == 6'h38 ? 32'h0000_0001 : a == 6'h39 ? 32'h0000_0000 : 32'h0000_1000);
            probe(32'h8000_0200, 0);
        end
    endtask
    task t_write_only;
        logic [5:0] adr [5] = '{6'h2f, 6'h39, 6'h3a, 6'h3b, 6'h3f};
        for (int i = 0; i < 5; i++) begin
            rdr(adr[i]);
            check("wo_fault", flt, 1);
        end
        rdr(6'h0c);
        check("base_rd", rd, 32'h0000_1000);
        check("rw_fault", flt, 0);
    endtask
    task t_diag_ctx;
        wr(6'h39, 32'h0000_0000);
        wr(6'h2f, 32'h0000_1000);
        probe(32'h0000_1000, 0);
        probe(32'h0000_1200, 0);
        wr(6'h3b, 32'h9800_0123);
        probe(32'h0000_1000, 1);
        wr(6'h2f, 32'h8000_1000);
        wr(6'h3b, 32'h9800_0123);
        probe(32'h0000_1000, 1);
        probe(32'h8000_1000, 1);
        @(posedge clk_sys_i);
        load_context_i <= 1;
        @(posedge clk_sys_i);
        load_context_i <= 0;
        probe(32'h0000_1000, 0);
        probe(32'h8000_1000, 1);
        n0 = n_mem;
        xlate(32'h8000_1004);
        check("diag_hit", n_mem - n0, 0);
        check("diag_pa", pa, {2'b00, 21'h00_0123, 9'h004});
    endtask
    task t_proc_walk;
        wr(6'h08, 32'h8000_2000);
        n0 = n_mem;
        xlate(32'h0000_0600);
        check("proc_fetches", n_mem - n0, 2);
        check("proc_fetch_addr", last_addr, 32'h0008_200c);
        check("proc_pa", pa, {2'b00, 21'h02_0803, 9'h000});
        check("proc_modified", xlate_modified_o, 1);
        xlate(32'h8000_0800);
        check("absent_fault", xf, 1);
        check("absent_modified", xlate_modified_o, 0);
    endtask
    task t_disabled;
        wr(6'h38, 0);
        rdr(6'h38);
        check("disable", rd, 0);
        n0 = n_mem;
        xlate(32'h8000_0a10);
        check("pa_off", pa, 32'h8000_0a10);
        check("no_fetch", n_mem - n0, 0);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rstn_i <= 1;
        t_reset_enable;
        t_miss_hit;
        t_flushes;
        t_write_only;
        t_diag_ctx;
        t_proc_walk;
        t_disabled;
        stop_test;
    end
endmodule // tb_top
`default_nettype wire
